/* core/pot_bus_master.sv */
// Bus master end: one-byte write or read transactions on the two-wire link
`timescale 1ns/1ps
module pot_bus_master
    import pot_link_pkg::*;
#(
    parameter int PU_LOCK_CYCLES = PU_LOCK_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    pot_link_if.master_end  link,
    input  wire logic       go,
    input  wire logic       go_read,
    input  wire logic [1:0] dev_sel,
    input  wire logic [7:0] wr_data,
    output logic            ready,
    output logic            done,
    output logic            acked,
    output logic [7:0]      rd_data
);
    typedef struct packed {
        mst_state_type   st;
        logic [Q_W-1:0]  q_cnt;
        logic [1:0]      phase;
        logic [3:0]      bit_idx;
        logic            byte_idx;
        logic [7:0]      shreg;
        logic [7:0]      wdata;
        logic            is_read;
        logic            ack;
        logic [1:0]      sda_sync;
        logic            scl_oe;
        logic            sda_oe;
        logic            ready;
        logic            done;
        logic            acked;
        logic [7:0]      rd_data;
        logic [PU_W-1:0] pu_cnt;
        logic            pu_done;
    } mst_regs_type;

    mst_regs_type s;
    mst_regs_type next_s;
    logic tick;
    logic sda_in;

    always_comb begin
        next_s = s;
        next_s.sda_sync = {s.sda_sync[0], link.sda};
        sda_in = s.sda_sync[1];
        next_s.done = 1'b0;
        tick = (s.q_cnt == Q_W'(SCL_QUARTER_CYC - 1));
        next_s.q_cnt = (tick || s.st == M_IDLE) ? '0 : Q_W'(s.q_cnt + 1'b1);
        if (tick) begin
            next_s.phase = s.phase + 1'b1;
        end
        if (!s.pu_done) begin
            if (s.pu_cnt == PU_W'(PU_LOCK_CYCLES - 1)) begin
                next_s.pu_done = 1'b1;
            end else begin
                next_s.pu_cnt = s.pu_cnt + 1'b1;
            end
        end
        case (s.st)
            M_IDLE: begin
                next_s.phase = '0;
                if (s.ready && go && sda_in) begin
                    next_s.ready = 1'b0;
                    next_s.is_read = go_read;
                    next_s.wdata = wr_data;
                    next_s.shreg = {DEV_TYPE_ID, dev_sel, go_read};
                    next_s.st = M_START;
                end else begin
                    next_s.ready = s.pu_done;
                end
            end
            M_START: begin
                if (tick) begin
                    if (s.phase == 2'h0) begin
                        next_s.sda_oe = 1'b1;
                    end else begin
                        next_s.scl_oe = 1'b1;
                        next_s.phase = '0;
                        next_s.bit_idx = '0;
                        next_s.byte_idx = 1'b0;
                        next_s.acked = 1'b0;
                        next_s.st = M_BITS;
                    end
                end
            end
            M_BITS: begin
                if (tick) begin
                    case (s.phase)
                        2'h0: begin
                            // Data changes only while clock low
                            if (s.bit_idx == BITS_PER_BYTE || (s.byte_idx && s.is_read)) begin
                                next_s.sda_oe = 1'b0;
                            end else begin
                                next_s.sda_oe = !s.shreg[7];
                            end
                        end
                        2'h1: begin
                            next_s.scl_oe = 1'b0;
                        end
                        2'h2: begin
                            if (s.bit_idx == BITS_PER_BYTE) begin
                                next_s.ack = !sda_in;
                                if (!(s.byte_idx && s.is_read)) begin
                                    next_s.acked = s.byte_idx ? (s.acked && !sda_in) : !sda_in;
                                end else begin
                                    next_s.rd_data = s.shreg;
                                end
                            end else begin
                                next_s.shreg = {s.shreg[6:0], sda_in};
                            end
                        end
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.bit_idx = s.bit_idx + 1'b1;
                            if (s.bit_idx == BITS_PER_BYTE) begin
                                next_s.bit_idx = '0;
                                if (!s.byte_idx && s.ack) begin
                                    next_s.byte_idx = 1'b1;
                                    next_s.shreg = s.is_read ? 8'hFF : s.wdata;
                                end else begin
                                    next_s.st = M_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tick) begin
                    case (s.phase)
                        2'h0: next_s.sda_oe = 1'b1;
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.sda_oe = 1'b0;
                        default: begin
                            next_s.done = 1'b1;
                            next_s.st = M_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= M_IDLE;
            s.sda_sync <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    assign link.scl_m_out = 1'b0;
    assign link.scl_m_oe = s.scl_oe;
    assign link.sda_m_out = 1'b0;
    assign link.sda_m_oe = s.sda_oe;
    assign ready = s.ready;
    assign done = s.done;
    assign acked = s.acked;
    assign rd_data = s.rd_data;
endmodule

/* core/pot_front_end.sv */
// Potentiometer serial slave front end with wiper and nonvolatile store
//
// Contract
// - Stop after write starts bounded program cycle
// - Busy programming: no acknowledge, data released
// - Master waits power-up lockout before access
// - Commanded wiper moves within latency window
// - Recalled wiper applied within power-up window
// - Master starts only on idle bus
// - Data change during clock high is condition
// - Master clocks; device never drives clock
// - Start is data falling, clock high
// - Glitches under filter time are suppressed
// - Stop is data rising, clock high
// - Receiver acknowledges in ninth clock
// - Respond only when address pins match
`timescale 1ns/1ps
module pot_front_end
    import pot_link_pkg::*;
#(
    parameter int NV_PROG_CYCLES  = NV_PROG_CYC,
    parameter int PU_LOCK_CYCLES  = PU_LOCK_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    pot_link_if.device_end  link,
    input  wire logic       addr_select_upper,
    input  wire logic       addr_select_lower,
    output logic [6:0]      wiper_position,
    output logic            nv_busy,
    output logic            link_ready
);
    typedef struct packed {
        dev_state_type     st;
        logic [1:0]        scl_sync;
        logic [1:0]        sda_sync;
        logic [1:0]        sel_s1;
        logic [1:0]        sel_s2;
        logic              scl_f;
        logic              sda_f;
        logic [FCNT_W-1:0] scl_fc;
        logic [FCNT_W-1:0] sda_fc;
        logic [3:0]        bit_cnt;
        logic [7:0]        shreg;
        logic              is_read;
        logic              got_data;
        logic              mack;
        logic [6:0]        wdata;
        logic              sda_oe;
        logic              busy;
        logic [NV_W-1:0]   nv_cnt;
        logic [6:0]        prog_val;
        logic [6:0]        nv_val;
        logic [6:0]        wiper;
        logic              lat_act;
        logic [LAT_W-1:0]  lat_cnt;
        logic [6:0]        pending;
        logic [PU_W-1:0]   pu_cnt;
        logic              pu_done;
    } dev_regs_type;

    dev_regs_type s;
    dev_regs_type next_s;
    logic [FCNT_W:0] scl_res;
    logic [FCNT_W:0] sda_res;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] tx;

    // Accept a new level only after one sample more than the filter time,
    // since a pulse just under it can still cover that many clock edges
    function automatic logic [FCNT_W:0] filt(input logic in, input logic cur,
                                             input logic [FCNT_W-1:0] cnt);
        logic [FCNT_W:0] r;
        r = {cur, {FCNT_W{1'b0}}};
        if (in != cur) begin
            if (cnt == FCNT_W'(FILT_CYC)) begin
                r = {in, {FCNT_W{1'b0}}};
            end else begin
                r = {cur, FCNT_W'(cnt + 1'b1)};
            end
        end
        return r;
    endfunction

    always_comb begin
        next_s = s;
        tx = {1'b0, s.wiper};
        next_s.scl_sync = {s.scl_sync[0], link.scl};
        next_s.sda_sync = {s.sda_sync[0], link.sda};
        next_s.sel_s1 = {addr_select_upper, addr_select_lower};
        next_s.sel_s2 = s.sel_s1;
        scl_res = filt(s.scl_sync[1], s.scl_f, s.scl_fc);
        sda_res = filt(s.sda_sync[1], s.sda_f, s.sda_fc);
        next_s.scl_f = scl_res[FCNT_W];
        next_s.scl_fc = scl_res[FCNT_W-1:0];
        next_s.sda_f = sda_res[FCNT_W];
        next_s.sda_fc = sda_res[FCNT_W-1:0];
        scl_rise = next_s.scl_f && !s.scl_f;
        scl_fall = !next_s.scl_f && s.scl_f;
        start_cond = s.scl_f && next_s.scl_f && s.sda_f && !next_s.sda_f;
        stop_cond = s.scl_f && next_s.scl_f && !s.sda_f && next_s.sda_f;

        if (!s.pu_done) begin
            if (s.pu_cnt == PU_W'(PU_LOCK_CYCLES - 1)) begin
                next_s.pu_done = 1'b1;
            end else begin
                next_s.pu_cnt = s.pu_cnt + 1'b1;
            end
        end

        if (s.lat_act) begin
            if (s.lat_cnt == LAT_W'(WIPER_LAT_CYC - 1)) begin
                next_s.lat_act = 1'b0;
                next_s.wiper = s.pending;
            end else begin
                next_s.lat_cnt = s.lat_cnt + 1'b1;
            end
        end

        if (s.busy) begin
            if (s.nv_cnt == NV_W'(NV_PROG_CYCLES - 1)) begin
                next_s.busy = 1'b0;
                next_s.nv_val = s.prog_val;
            end else begin
                next_s.nv_cnt = s.nv_cnt + 1'b1;
            end
        end

        if (start_cond) begin
            next_s.sda_oe = 1'b0;
            next_s.bit_cnt = '0;
            next_s.got_data = 1'b0;
            // Ignore address while busy or locked out
            next_s.st = (s.busy || !s.pu_done) ? D_IDLE : D_ADDR;
        end else if (stop_cond) begin
            next_s.sda_oe = 1'b0;
            next_s.st = D_IDLE;
            if (s.got_data && !s.is_read && s.st != D_IDLE) begin
                next_s.busy = 1'b1;
                next_s.nv_cnt = '0;
                next_s.prog_val = s.wdata;
                next_s.lat_act = 1'b1;
                next_s.lat_cnt = '0;
                next_s.pending = s.wdata;
            end
        end else begin
            case (s.st)
                D_ADDR, D_WR: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], s.sda_f};
                        next_s.bit_cnt = s.bit_cnt + 1'b1;
                    end else if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
                        next_s.bit_cnt = '0;
                        if (s.st == D_WR) begin
                            next_s.wdata = s.shreg[6:0];
                            next_s.got_data = 1'b1;
                            next_s.sda_oe = 1'b1;
                            next_s.st = D_ACK;
                        end else if (s.shreg[7:ID_LSB] == DEV_TYPE_ID
                                && s.shreg[SEL_HI_BIT] == s.sel_s2[1]
                                && s.shreg[SEL_LO_BIT] == s.sel_s2[0]) begin
                            next_s.is_read = s.shreg[RW_BIT];
                            next_s.sda_oe = 1'b1;
                            next_s.st = D_ACK;
                        end else begin
                            next_s.st = D_WAIT;
                        end
                    end
                end
                D_ACK: begin
                    if (scl_fall) begin
                        next_s.bit_cnt = '0;
                        if (s.is_read) begin
                            next_s.sda_oe = !tx[7];
                            next_s.shreg = {tx[6:0], 1'b0};
                            next_s.st = D_RD;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.st = D_WR;
                        end
                    end
                end
                D_RD: begin
                    if (scl_rise) begin
                        next_s.bit_cnt = s.bit_cnt + 1'b1;
                    end else if (scl_fall) begin
                        if (s.bit_cnt == BITS_PER_BYTE) begin
                            next_s.sda_oe = 1'b0;
                            next_s.st = D_RACK;
                        end else begin
                            next_s.sda_oe = !s.shreg[7];
                            next_s.shreg = {s.shreg[6:0], 1'b0};
                        end
                    end
                end
                D_RACK: begin
                    if (scl_rise) begin
                        next_s.mack = !s.sda_f;
                    end else if (scl_fall) begin
                        next_s.bit_cnt = '0;
                        if (s.mack) begin
                            next_s.sda_oe = !tx[7];
                            next_s.shreg = {tx[6:0], 1'b0};
                            next_s.st = D_RD;
                        end else begin
                            next_s.st = D_WAIT;
                        end
                    end
                end
                default: begin
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= D_IDLE;
            s.scl_sync <= 2'h3;
            s.sda_sync <= 2'h3;
            s.scl_f <= 1'b1;
            s.sda_f <= 1'b1;
            s.nv_val <= NV_DEFAULT;
            s.wiper <= WIPER_MID;
            s.lat_act <= 1'b1;
            s.pending <= NV_DEFAULT;
        end else begin
            s <= next_s;
        end
    end

    // Only the data line is ever driven
    assign link.sda_s_out = 1'b0;
    assign link.sda_s_oe = s.sda_oe;
    assign wiper_position = s.wiper;
    assign nv_busy = s.busy;
    assign link_ready = s.pu_done;
endmodule

/* include/pot_link_if.sv */
// Two-wire link between bus master and potentiometer front end
`timescale 1ns/1ps
interface pot_link_if;
    logic scl_m_out;
    logic scl_m_oe;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_s_out;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // Open-drain wired-AND with pull-up
    assign scl = !(scl_m_oe && !scl_m_out);
    assign sda = !(sda_m_oe && !sda_m_out) && !(sda_s_oe && !sda_s_out);

    modport master_end (output scl_m_out, output scl_m_oe, output sda_m_out,
                        output sda_m_oe, input scl, input sda);
    modport device_end (output sda_s_out, output sda_s_oe, input scl, input sda);
endinterface

/* include/pot_link_pkg.sv */
// Shared constants and state encodings for the potentiometer serial link
package pot_link_pkg;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int FILT_NS          = 50;
    localparam int FILT_CYC         = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIPER_LAT_MIN_NS = 5000;
    localparam int WIPER_LAT_CYC    = (WIPER_LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_PROG_NS       = 5000000;
    localparam int NV_PROG_CYC      = NV_PROG_NS / CLK_PERIOD_NS;
    localparam int PU_LOCK_NS       = 1000000;
    localparam int PU_LOCK_CYC      = PU_LOCK_NS / CLK_PERIOD_NS;
    localparam int SCL_PERIOD_NS    = 2500;
    localparam int SCL_QUARTER_CYC  = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                      / (4 * CLK_PERIOD_NS);

    localparam int FCNT_W = 3;
    localparam int LAT_W  = 10;
    localparam int NV_W   = 20;
    localparam int PU_W   = 17;
    localparam int Q_W    = 7;

    localparam logic [4:0] DEV_TYPE_ID   = 5'h0A;
    localparam int         ID_LSB        = 3;
    localparam int         SEL_HI_BIT    = 2;
    localparam int         SEL_LO_BIT    = 1;
    localparam int         RW_BIT        = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] WIPER_MID     = 7'h40;
    localparam logic [6:0] NV_DEFAULT    = 7'h40;

    typedef enum logic [6:0] {
        D_IDLE = 7'h01,
        D_ADDR = 7'h02,
        D_ACK  = 7'h04,
        D_WR   = 7'h08,
        D_RD   = 7'h10,
        D_RACK = 7'h20,
        D_WAIT = 7'h40
    } dev_state_type;

    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_START = 4'h2,
        M_BITS  = 4'h4,
        M_STOP  = 4'h8
    } mst_state_type;
endpackage

/* sim/pot_link_props.sv */
// Concurrent checks on the link joining bus master and front end
`timescale 1ns/1ps
module pot_link_props (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_m_out,
    input wire logic scl_m_oe,
    input wire logic sda_m_out,
    input wire logic sda_m_oe,
    input wire logic sda_s_out,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    // Longest legal transaction here is two bytes, well under this bound
    localparam int TXN_MAX = 8000;
    logic in_txn;
    logic sda_q;
    int   txn_cnt;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_start; scl && $fell(sda); endsequence
    sequence s_stop; scl && $rose(sda); endsequence
    sequence s_next_fall; ##[1:300] $fell(scl); endsequence

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_q   <= 1'b1;
            in_txn  <= 1'b0;
            txn_cnt <= 0;
        end else begin
            sda_q   <= sda;
            if (scl && sda_q && !sda)
                in_txn <= 1'b1;
            else if (scl && !sda_q && sda)
                in_txn <= 1'b0;
            txn_cnt <= in_txn ? txn_cnt + 1 : 0;
        end
    end

    a_start_bus_idle: assert property (s_start |-> !in_txn)
        else $error("start inside a transaction");
    a_stop_closes: assert property (s_stop |-> in_txn)
        else $error("stop without a transaction");
    a_txn_bounded: assert property (in_txn |-> txn_cnt < TXN_MAX)
        else $error("transaction never stopped");
    a_dev_hold_high: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("device data moved with clock high");
    a_dev_after_start: assert property ($rose(sda_s_oe) |-> in_txn)
        else $error("device drove data outside a transaction");
    a_dev_drive_delay: assert property ($rose(sda_s_oe) |-> !scl && !$past(scl, 5))
        else $error("device drove data too soon after clock fall");
    a_ack_stands: assert property ($rose(sda_s_oe) |-> sda_s_oe throughout s_next_fall)
        else $error("device let go before the clock fell");
    a_dev_release: assert property ($fell(sda_s_oe) |-> !scl && !$past(scl, 5))
        else $error("device released data at a bad moment");
    a_open_drain: assert property (!sda_s_out && !scl_m_out && !sda_m_out)
        else $error("a party drove a line high");
    a_mst_hold_high: assert property ($changed(sda_m_oe) && scl |-> sda_m_oe != in_txn)
        else $error("master data moved with clock high");
endmodule

/* sim/tb_pot_i2c_slave_front_end.sv */
// Bench: master and front end joined, plus a hand-driven second link
`timescale 1ns/1ps
module tb_pot_i2c_slave_front_end;
    import pot_link_pkg::*;
    // Shortened counts keep the run brief
    localparam int PU_CYC = 50;
    localparam int NV_CYC = 3000;
    localparam int Q      = 20;
    localparam int LIMIT  = 60000;
    logic       ref_clk;
    logic       rst_b;
    logic       go;
    logic       go_read;
    logic [1:0] dev_sel;
    logic [7:0] wr_data;
    logic [1:0] pin_sel;
    logic       ready;
    logic       done;
    logic       acked;
    logic [7:0] rd_data;
    logic [6:0] wiper;
    logic       busy;
    logic       link_ready;
    logic [6:0] wiper_b;
    logic       busy_b;
    logic       ack;
    logic       s;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    pot_link_if lnk ();
    pot_link_if lnk_b ();

    pot_front_end #(.NV_PROG_CYCLES(NV_CYC), .PU_LOCK_CYCLES(PU_CYC)) i_pot_front_end (
        .ref_clk(ref_clk), .rst_b(rst_b), .link(lnk),
        .addr_select_upper(pin_sel[1]), .addr_select_lower(pin_sel[0]),
        .wiper_position(wiper), .nv_busy(busy), .link_ready(link_ready));
    pot_front_end #(.NV_PROG_CYCLES(NV_CYC), .PU_LOCK_CYCLES(PU_CYC)) i_pot_front_end_b (
        .ref_clk(ref_clk), .rst_b(rst_b), .link(lnk_b),
        .addr_select_upper(pin_sel[1]), .addr_select_lower(pin_sel[0]),
        .wiper_position(wiper_b), .nv_busy(busy_b), .link_ready());
    pot_bus_master #(.PU_LOCK_CYCLES(PU_CYC)) i_pot_bus_master (
        .ref_clk(ref_clk), .rst_b(rst_b), .link(lnk), .go(go), .go_read(go_read),
        .dev_sel(dev_sel), .wr_data(wr_data), .ready(ready), .done(done),
        .acked(acked), .rd_data(rd_data));
    pot_link_props i_pot_link_props (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_m_out(lnk.scl_m_out),
        .scl_m_oe(lnk.scl_m_oe), .sda_m_out(lnk.sda_m_out), .sda_m_oe(lnk.sda_m_oe),
        .sda_s_out(lnk.sda_s_out), .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));

    task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task finish_test;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task xfer(input logic rd, input logic [1:0] sel, input logic [7:0] d);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        go <= 1'b1;
        go_read <= rd;
        dev_sel <= sel;
        wr_data <= d;
        @(posedge ref_clk);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        check(done, 1'b1, "transfer end");
    endtask

    // One bit on the hand-driven link; data sampled with the clock high
    task bb(input logic b);
        lnk_b.sda_m_oe <= !b;
        wait_cyc(Q);
        lnk_b.scl_m_oe <= 1'b0;
        wait_cyc(Q);
        s = lnk_b.sda;
        wait_cyc(Q);
        lnk_b.scl_m_oe <= 1'b1;
        wait_cyc(Q);
    endtask

    task bb_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bb(v[i]);
        end
        bb(1'b1);
        ack = !s;
    endtask

    task bb_start;
        lnk_b.sda_m_oe <= 1'b1;
        wait_cyc(Q);
        lnk_b.scl_m_oe <= 1'b1;
        wait_cyc(Q);
    endtask

    task bb_stop;
        lnk_b.sda_m_oe <= 1'b1;
        wait_cyc(Q);
        lnk_b.scl_m_oe <= 1'b0;
        wait_cyc(Q);
        lnk_b.sda_m_oe <= 1'b0;
        wait_cyc(Q);
    endtask

    task t_powerup;
        @(posedge ref_clk);
        check(link_ready, 1'b0, "lockout");
        check(wiper, 7'h40, "mid-scale");
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wait_cyc(100);
        check(lnk.sda, 1'b1, "go in lockout");
        check(link_ready, 1'b1, "lockout over");
        wait_cyc(500);
        check(wiper, NV_DEFAULT, "recall");
    endtask

    task t_write_poll;
        xfer(1'b0, pin_sel, 8'hD5);
        check(acked, 1'b1, "write ack");
        check(busy, 1'b1, "busy after stop");
        check(wiper, 7'h40, "wiper early");
        fork
            xfer(1'b0, pin_sel, 8'h11);
            begin
                // First look falls before the minimum latency seen from the stop, the second after it
                wait_cyc(400);
                check(wiper, 7'h40, "wiper before min");
                wait_cyc(500);
                check(wiper, 7'h55, "wiper by max");
            end
        join
        check(acked, 1'b0, "ack while busy");
        wait_cyc(NV_CYC);
        check(busy, 1'b0, "program end");
        check(wiper, 7'h55, "refused write");
    endtask

    task t_reads;
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, 2'(k), 8'h00);
            check(acked, 2'(k) == pin_sel, "address match");
            if (2'(k) == pin_sel) begin
                check(rd_data, 8'h55, "read value");
            end
        end
    endtask

    task t_filter_abort;
        // A 30 ns dip with the clock high must not open a transfer
        lnk_b.sda_m_oe <= 1'b1;
        wait_cyc(3);
        lnk_b.sda_m_oe <= 1'b0;
        wait_cyc(Q);
        lnk_b.scl_m_oe <= 1'b1;
        wait_cyc(Q);
        bb_byte({DEV_TYPE_ID, pin_sel, 1'b0});
        check(ack, 1'b0, "no start");
        bb_stop();
        bb_start();
        bb_byte({DEV_TYPE_ID, pin_sel, 1'b0});
        check(ack, 1'b1, "ack after start");
        repeat (3) bb(1'b1);
        lnk_b.scl_m_oe <= 1'b0;
        wait_cyc(Q);
        bb_start();
        bb_byte({DEV_TYPE_ID, pin_sel, 1'b0});
        check(ack, 1'b1, "ack after restart");
        bb_stop();
        wait_cyc(600);
        check(busy_b, 1'b0, "no program");
        check(wiper_b, 7'h40, "wiper kept");
    endtask

    // Two-byte read: master acks the first byte, refuses the second
    task t_read_twice;
        logic [7:0] v;
        bb_start();
        bb_byte({DEV_TYPE_ID, pin_sel, 1'b1});
        check(ack, 1'b1, "read address");
        for (int n = 0; n < 2; n++) begin
            for (int i = 0; i < 8; i++) begin
                bb(1'b1);
                v = {v[6:0], s};
            end
            check(v, {1'b0, WIPER_MID}, "read byte");
            bb(n == 1);
        end
        bb_stop();
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        go = 1'b0;
        go_read = 1'b0;
        dev_sel = 2'h0;
        wr_data = 8'h00;
        pin_sel = 2'h2;
        ack = 1'b0;
        s = 1'b0;
        lnk_b.scl_m_out = 1'b0;
        lnk_b.sda_m_out = 1'b0;
        lnk_b.scl_m_oe = 1'b0;
        lnk_b.sda_m_oe = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_powerup();
        t_write_poll();
        t_reads();
        t_filter_abort();
        t_read_twice();
        finish_test();
    end
endmodule
